// File: hdl/frse_top.sv
/*
  frse_top: flash row service engine. Serves supervisory calls from the
  core, reads the parameter block, programs, erases, protects, fetches
  tables and checksums rows, and exposes control and status over APB.
  Assumes SRAM and flash answer one cycle after rd, on clk.
*/
// Design decisions made here: the address map and the APB interface to the registers.
// Functional notes
// - pulse length set by divider and delay
// - program sources 64 bytes from pointer
// - erase one row after protection check
// - refused erase: acc, second_guard_key zero, first_guard_key 01h
// - divider sets erase pulse width
// - two-bit protection level per row
// - four levels per byte, low row low
// - indexed rom reads never gated by protection
// - levels only lowered by bulk erase
// - merge ORs SRAM 80h block into protection
// - row erase keeps protection level
// - bulk: erase, zero, erase, then protection
// - bulk leaves other hidden rows alone
// - table fetch: low three bits, to F8h-FFh
// - id table returns die revision in A,X
// - trim table returns count, X=FFh
// - internal revision count starts at zero
// - checksum rows from 0, zero means 256
// - checksum carry into high, low in first_guard_key
// - accumulator code selects the command
// - bad key halts the core
// - first_guard_key returns 00h ok, 01h protected
`timescale 1ns/1ps
module frse_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input frse_pkg::frse_apb_req_type apb_req,
  output frse_pkg::frse_apb_resp_type apb_resp,
  input frse_pkg::frse_call_type core_call,
  output frse_pkg::frse_core_type core_ctl,
  input wire logic [7:0] sram_rdata,
  output frse_pkg::frse_sram_type sram_req,
  input wire logic [7:0] flash_rdata,
  output frse_pkg::frse_flash_type flash_req
);
  import frse_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_PARM, S_CHECK, S_PROT, S_LOAD, S_PULSE, S_MERGE,
    S_TABLE, S_ACCX, S_SUM, S_RES, S_DONE, S_HALT
  } frse_state_type;

  typedef struct packed {
    frse_state_type st;
    logic [1:0] ph;
    logic [13:0] i;
    logic [2:0] step;
    logic [7:0] cmd;
    logic [7:0] sp;
    logic [7:0] first_guard_key;
    logic [7:0] second_guard_key;
    logic [7:0] blk;
    logic [7:0] ptr;
    logic [7:0] div;
    logic [7:0] dly;
    logic fail;
    logic [15:0] sum;
    logic [7:0] pre;
    logic [7:0] divc;
    logic en;
    logic [7:0] last_res;
    frse_core_type core;
    frse_sram_type sram;
    frse_flash_type fl;
    frse_apb_resp_type apb;
  } frse_regs_type;

  frse_regs_type r;
  frse_regs_type n;
  logic [7:0] sh;
  logic [14:0] total;
  logic last_step;

  // pulse target for a command step
  function automatic frse_flash_type pulse_cfg(
    input logic [7:0] c,
    input logic [2:0] s,
    input logic [7:0] b,
    input frse_flash_type f
  );
    frse_flash_type o;
    o = f;
    o.all = 1'b0;
    o.aux = 1'b0;
    o.row = b;
    o.col = 6'h00;
    o.rd = 1'b0;
    o.ld = 1'b0;
    unique case (c)
      CMD_PROG: o.op = OP_PROG;
      CMD_ERASE: o.op = OP_ERASE;
      CMD_MERGE: begin
        o.aux = 1'b1;
        o.row = PROT_ROW;
        o.op = (s == 3'h0) ? OP_ERASE : OP_PROG;
      end
      default: begin
        // user space first, then only the protection row
        o.all = (s < 3'h3);
        o.aux = (s >= 3'h3);
        o.row = PROT_ROW;
        o.op = (s == 3'h1 || s == BULK_LAST) ? OP_ZERO : OP_ERASE;
      end
    endcase
    return o;
  endfunction

  always_comb begin
    sh = flash_rdata >> {r.blk[1:0], 1'b0};
    total = (r.blk == 8'h00) ? ALL_ROWS_BYTES : {1'b0, r.blk, 6'h00};
    last_step = (r.cmd == CMD_PROG) || (r.cmd == CMD_ERASE) ||
      (r.cmd == CMD_MERGE && r.step == 3'h1) ||
      (r.cmd == CMD_BULK && r.step == BULK_LAST);
    n = r;
    n.sram.rd = 1'b0;
    n.sram.we = 1'b0;
    n.fl.rd = 1'b0;
    n.fl.ld = 1'b0;
    n.core.acc_we = 1'b0;
    n.core.x_we = 1'b0;
    n.apb.pready = 1'b0;
    n.apb.pslverr = 1'b0;
    // apb: read data set up in the setup phase, write at the access edge
    if (apb_req.psel && !apb_req.penable) begin
      n.apb.pready = 1'b1;
      n.apb.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        CTRL_OFF: n.apb.prdata = {31'h0000_0000, r.en};
        STAT_OFF: n.apb.prdata = {8'h00, r.cmd, r.last_res, 6'h00,
          r.core.halt, r.core.stall};
        CSUM_OFF: n.apb.prdata = {16'h0000, r.sum};
        default: n.apb.pslverr = 1'b1;
      endcase
    end
    if (apb_req.psel && apb_req.penable && r.apb.pready &&
        apb_req.pwrite && apb_req.paddr == CTRL_OFF) begin
      n.en = apb_req.pwdata[0];
    end
    unique case (r.st)
      S_IDLE: begin
        if (core_call.call && r.en) begin
          n.cmd = core_call.acc;
          n.sp = core_call.sp;
          n.core.stall = 1'b1;
          n.st = S_PARM;
          n.i = 14'h0000;
          n.ph = 2'h0;
        end
      end
      S_PARM: begin
        if (r.ph == 2'h0) begin
          n.sram.rd = 1'b1;
          n.sram.addr = FIRST_GUARD_KEY_ADDR + {5'h00, r.i[2:0]};
        end
        if (r.ph == 2'h2) begin
          case (r.i[2:0])
            3'h0: n.first_guard_key = sram_rdata;
            3'h1: n.second_guard_key = sram_rdata;
            3'h2: n.blk = sram_rdata;
            3'h3: n.ptr = sram_rdata;
            3'h4: n.div = sram_rdata;
            3'h6: n.dly = sram_rdata;
            default: n.first_guard_key = r.first_guard_key;
          endcase
          n.ph = 2'h0;
          n.i = r.i + 14'h0001;
          if (r.i[2:0] == PARM_LAST) begin
            n.st = S_CHECK;
          end
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_CHECK: begin
        n.i = 14'h0000;
        n.ph = 2'h0;
        n.step = 3'h0;
        n.fail = 1'b0;
        if (r.first_guard_key != FIRST_GUARD_KEY_VAL || r.second_guard_key != r.sp) begin
          n.st = S_HALT;
        end else begin
          unique case (r.cmd)
            CMD_PROG, CMD_ERASE: n.st = S_PROT;
            CMD_MERGE: n.st = S_MERGE;
            CMD_BULK: begin
              n.fl = pulse_cfg(r.cmd, 3'h0, r.blk, r.fl);
              n.pre = r.dly;
              n.divc = r.div;
              n.st = S_PULSE;
            end
            CMD_TABLE: n.st = S_TABLE;
            CMD_CSUM: begin
              n.sum = 16'h0000;
              n.st = S_SUM;
            end
            default: n.st = S_HALT;
          endcase
        end
      end
      S_PROT: begin
        if (r.ph == 2'h0) begin
          n.fl.rd = 1'b1;
          n.fl.aux = 1'b1;
          n.fl.all = 1'b0;
          n.fl.row = PROT_ROW;
          n.fl.col = r.blk[7:2];
        end
        if (r.ph == 2'h2) begin
          n.ph = 2'h0;
          // internal writes are refused only at the top level
          if (sh[1:0] == LVL_INTW) begin
            n.fail = 1'b1;
            n.st = S_RES;
          end else if (r.cmd == CMD_PROG) begin
            n.st = S_LOAD;
          end else begin
            n.fl = pulse_cfg(r.cmd, 3'h0, r.blk, r.fl);
            n.pre = r.dly;
            n.divc = r.div;
            n.st = S_PULSE;
          end
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_LOAD: begin
        if (r.i[6]) begin
          // last byte latches at the end of this cycle: now start the pulse
          n.fl = pulse_cfg(r.cmd, 3'h0, r.blk, r.fl);
          n.pre = r.dly;
          n.divc = r.div;
          n.st = S_PULSE;
        end else if (r.ph == 2'h0) begin
          n.sram.rd = 1'b1;
          n.sram.addr = r.ptr + r.i[7:0];
          n.ph = 2'h1;
        end else if (r.ph == 2'h2) begin
          n.fl.ld = 1'b1;
          n.fl.aux = 1'b0;
          n.fl.col = r.i[5:0];
          n.fl.wdata = sram_rdata;
          n.ph = 2'h0;
          n.i = r.i + 14'h0001;
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_MERGE: begin
        if (r.i[6]) begin
          n.fl = pulse_cfg(r.cmd, 3'h0, r.blk, r.fl);
          n.pre = r.dly;
          n.divc = r.div;
          n.st = S_PULSE;
        end else if (r.ph == 2'h0) begin
          n.sram.rd = 1'b1;
          n.sram.addr = MERGE_BASE + {2'h0, r.i[5:0]};
          n.fl.rd = 1'b1;
          n.fl.aux = 1'b1;
          n.fl.row = PROT_ROW;
          n.fl.col = r.i[5:0];
          n.ph = 2'h1;
        end else if (r.ph == 2'h2) begin
          n.fl.ld = 1'b1;
          n.fl.wdata = sram_rdata | flash_rdata;
          n.ph = 2'h0;
          n.i = r.i + 14'h0001;
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_PULSE: begin
        // pulse lasts (divider + 1) * (delay + 1) cycles
        if (r.pre != 8'h00) begin
          n.pre = r.pre - 8'h01;
        end else if (r.divc != 8'h00) begin
          n.pre = r.dly;
          n.divc = r.divc - 8'h01;
        end else if (last_step) begin
          n.fl.op = OP_NONE;
          n.fl.all = 1'b0;
          n.fl.aux = 1'b0;
          n.st = S_RES;
        end else begin
          n.step = r.step + 3'h1;
          n.fl = pulse_cfg(r.cmd, r.step + 3'h1, r.blk, r.fl);
          n.pre = r.dly;
          n.divc = r.div;
        end
      end
      S_TABLE: begin
        if (r.ph == 2'h0) begin
          n.fl.rd = 1'b1;
          n.fl.aux = 1'b1;
          n.fl.row = TBL_ROW;
          n.fl.col = {r.blk[2:0], r.i[2:0]};
        end
        if (r.ph == 2'h2) begin
          n.sram.we = 1'b1;
          n.sram.addr = TBL_BASE + {5'h00, r.i[2:0]};
          n.sram.wdata = flash_rdata;
          n.ph = 2'h0;
          n.i = r.i + 14'h0001;
          if (r.i[2:0] == 3'h7) begin
            n.st = S_ACCX;
          end
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_ACCX: begin
        if (r.blk[2:0] == TBL_ID) begin
          n.core.acc_we = 1'b1;
          n.core.x_we = 1'b1;
          n.core.acc = DIE_REV[15:8];
          n.core.x = DIE_REV[7:0];
        end else if (r.blk[2:0] == TBL_TRIM) begin
          n.core.acc_we = 1'b1;
          n.core.x_we = 1'b1;
          n.core.acc = INT_REV;
          n.core.x = XREG_TRIM;
        end
        n.st = S_DONE;
      end
      S_SUM: begin
        if (r.ph == 2'h0) begin
          n.fl.rd = 1'b1;
          n.fl.aux = 1'b0;
          n.fl.row = r.i[13:6];
          n.fl.col = r.i[5:0];
        end
        if (r.ph == 2'h2) begin
          n.sum = r.sum + {8'h00, flash_rdata};
          n.ph = 2'h0;
          n.i = r.i + 14'h0001;
          if ({1'b0, r.i} + 15'h0001 == total) begin
            n.st = S_RES;
          end
        end else begin
          n.ph = r.ph + 2'h1;
        end
      end
      S_RES: begin
        n.sram.we = 1'b1;
        if (r.ph == 2'h0) begin
          n.sram.addr = FIRST_GUARD_KEY_ADDR;
          if (r.cmd == CMD_CSUM) begin
            n.sram.wdata = r.sum[7:0];
          end else begin
            n.sram.wdata = r.fail ? RES_PROT : RES_OK;
          end
          n.last_res = n.sram.wdata;
          n.ph = 2'h1;
        end else begin
          n.sram.addr = SECOND_GUARD_KEY_ADDR;
          n.sram.wdata = (r.cmd == CMD_CSUM) ? r.sum[15:8] : RES_OK;
          if (r.cmd != CMD_CSUM) begin
            n.core.acc_we = 1'b1;
            n.core.acc = RES_OK;
          end
          n.ph = 2'h0;
          n.st = S_DONE;
        end
      end
      S_DONE: begin
        n.core.stall = 1'b0;
        n.st = S_IDLE;
      end
      S_HALT: begin
        n.core.halt = 1'b1;
        n.core.stall = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.en <= CTRL_EN_RST;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign apb_resp = r.apb;
  assign core_ctl = r.core;
  assign sram_req = r.sram;
  assign flash_req = r.fl;

  // helper: cycles since the pulse target last changed
  logic [16:0] pcnt;
  logic [16:0] plen;
  assign plen = ({9'h000, r.div} + 17'h00001) * ({9'h000, r.dly} + 17'h00001);
  always_ff @(posedge clk) begin
    if (reset) begin
      pcnt <= '0;
    end else if (clk_en) begin
      if ({n.fl.op, n.fl.all, n.fl.aux} != {r.fl.op, r.fl.all, r.fl.aux}) begin
        pcnt <= '0;
      end else begin
        pcnt <= pcnt + 17'h00001;
      end
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (reset || !clk_en);

  sequence bad_key_s;
    r.st == S_CHECK && (r.first_guard_key != FIRST_GUARD_KEY_VAL || r.second_guard_key != r.sp);
  endsequence
  sequence halted_s;
    core_ctl.halt && !core_ctl.stall;
  endsequence

  key_halt_a: assert property (bad_key_s |=> ##1 halted_s)
    else $error("bad guard key did not halt the core");

  pulse_len_a: assert property (
    r.st == S_PULSE && r.pre == 8'h00 && r.divc == 8'h00 |->
      pcnt + 17'h00001 == plen)
    else $error("pulse width differs from divider times delay");

  refuse_code_a: assert property (
    r.st == S_RES && r.ph == 2'h0 && r.fail |=>
      sram_req.we && sram_req.addr == FIRST_GUARD_KEY_ADDR &&
      sram_req.wdata == RES_PROT ##1
      sram_req.we && sram_req.addr == SECOND_GUARD_KEY_ADDR &&
      sram_req.wdata == RES_OK && core_ctl.acc_we && core_ctl.acc == RES_OK)
    else $error("refused command returned wrong results");

  prog_src_a: assert property (
    flash_req.ld && r.cmd == CMD_PROG |->
      flash_req.wdata == $past(sram_rdata) &&
      $past(sram_req.addr, 2) == r.ptr + {2'h0, flash_req.col})
    else $error("program byte not taken from pointer area");

  merge_or_a: assert property (
    flash_req.ld && r.cmd == CMD_MERGE |->
      flash_req.wdata == ($past(sram_rdata) | $past(flash_rdata)))
    else $error("merge byte is not the OR of SRAM and stored level");

  prot_keep_a: assert property (
    flash_req.op == OP_ERASE && flash_req.aux |->
      r.cmd == CMD_MERGE || r.cmd == CMD_BULK)
    else $error("protection row erased outside merge or bulk erase");

  table_dest_a: assert property (
    sram_req.we && r.cmd == CMD_TABLE && r.st != S_RES |->
      sram_req.addr >= TBL_BASE)
    else $error("table byte written outside the parameter block");

  trim_x_a: assert property (
    core_ctl.x_we && r.blk[2:0] == TBL_TRIM |->
      core_ctl.x == XREG_TRIM && core_ctl.acc == INT_REV)
    else $error("trim table fetch returned wrong A or X");

  csum_high_a: assert property (
    sram_req.we && sram_req.addr == SECOND_GUARD_KEY_ADDR && r.cmd == CMD_CSUM |->
      sram_req.wdata == r.sum[15:8] && $past(sram_req.wdata) == r.sum[7:0])
    else $error("checksum bytes returned in the wrong slots");

  stall_end_a: assert property (
    $fell(core_ctl.stall) && !core_ctl.halt |->
      $past(sram_req.we) || $past(core_ctl.acc_we) || $past(r.st) == S_DONE)
    else $error("core released before results were written");
endmodule // frse_top

// File: hdl/frse_pkg.sv
/*
  frse_pkg: constants and carrier types of the flash row service engine.
  Assumes a byte-wide SRAM and a flash macro port, both with one cycle of
  read latency, and an APB master on the same clock.
*/
package frse_pkg;
  // parameter block slots at the top of SRAM
  localparam logic [7:0] FIRST_GUARD_KEY_ADDR = 8'hf8;
  localparam logic [7:0] FIRST_GUARD_KEY_VAL = 8'h3a;
  localparam logic [7:0] SECOND_GUARD_KEY_ADDR = 8'hf9;
  localparam logic [7:0] MERGE_BASE = 8'h80;
  localparam logic [7:0] TBL_BASE = 8'hf8;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_PROT = 8'h01;
  localparam logic [7:0] XREG_TRIM = 8'hff;
  localparam logic [2:0] PARM_LAST = 3'h6;
  // command codes in the accumulator
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_MERGE = 8'h04;
  localparam logic [7:0] CMD_BULK = 8'h05;
  localparam logic [7:0] CMD_TABLE = 8'h06;
  localparam logic [7:0] CMD_CSUM = 8'h07;
  // protection levels
  localparam logic [1:0] LVL_OPEN = 2'b00;
  localparam logic [1:0] LVL_READ = 2'b01;
  localparam logic [1:0] LVL_EXTW = 2'b10;
  localparam logic [1:0] LVL_INTW = 2'b11;
  // hidden rows and tables
  localparam logic [7:0] PROT_ROW = 8'h00;
  localparam logic [7:0] TBL_ROW = 8'h01;
  localparam logic [2:0] TBL_ID = 3'h0;
  localparam logic [2:0] TBL_TRIM = 3'h1;
  localparam logic [14:0] ALL_ROWS_BYTES = 15'h4000;
  localparam logic [2:0] BULK_LAST = 3'h4;
  // die revision and internal revision count: values are arbitrary
  localparam logic [15:0] DIE_REV = 16'h5a01;
  localparam logic [7:0] INT_REV = 8'h00;
  // apb register map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] CSUM_OFF = 12'h008;
  localparam logic CTRL_EN_RST = 1'b1;

  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROG, OP_ZERO} frse_op_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } frse_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } frse_apb_resp_type;

  typedef struct packed {
    logic call;
    logic [7:0] acc;
    logic [7:0] sp;
  } frse_call_type;

  typedef struct packed {
    logic stall;
    logic halt;
    logic acc_we;
    logic [7:0] acc;
    logic x_we;
    logic [7:0] x;
  } frse_core_type;

  typedef struct packed {
    logic rd;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } frse_sram_type;

  typedef struct packed {
    frse_op_type op;
    logic all;
    logic aux;
    logic rd;
    logic ld;
    logic [7:0] row;
    logic [5:0] col;
    logic [7:0] wdata;
  } frse_flash_type;
endpackage

// File: test/frse_mem.sv
/*
  frse_mem: sram and flash array partner of the service engine.
  Assumes one cycle of read latency on both ports, same clk as the engine.
*/
`timescale 1ns/1ps
module frse_mem import frse_pkg::*; (
  input wire logic clk,
  input frse_pkg::frse_sram_type sram_req,
  output logic [7:0] sram_rdata,
  input frse_pkg::frse_flash_type flash_req,
  output logic [7:0] flash_rdata
);
  logic [7:0] sram [256];
  logic [7:0] user [16384];
  logic [7:0] prot [64];
  logic [7:0] tbl [64];
  logic [7:0] latch [64];
  frse_op_type op_q = OP_NONE;
  logic [3:0] tgt_q = 4'h0;
  int run = 0;
  int pulse_len = 0;
  initial sram_rdata = 8'h00;
  initial flash_rdata = 8'h00;
  // one pulse acts once, at its first cycle; program only clears bits
  task automatic apply(input frse_flash_type f);
    int n;
    logic [7:0] v;
    n = f.all ? 16384 : 64;
    for (int i = 0; i < n; i++) begin
      if (f.aux) v = f.row[0] ? tbl[i[5:0]] : prot[i[5:0]];
      else v = f.all ? user[i] : user[{f.row, i[5:0]}];
      case (f.op)
        OP_ERASE: v = 8'hff;
        OP_ZERO: v = 8'h00;
        default: v = v & latch[i[5:0]];
      endcase
      if (f.aux && f.row[0]) tbl[i[5:0]] = v;
      else if (f.aux) prot[i[5:0]] = v;
      else if (f.all) user[i] = v;
      else user[{f.row, i[5:0]}] = v;
    end
  endtask
  always @(posedge clk) begin
    // idle read lines show the inverse of the last value
    sram_rdata <= sram_req.rd ? sram[sram_req.addr] : ~sram_rdata;
    if (sram_req.we) sram[sram_req.addr] <= sram_req.wdata;
    if (!flash_req.rd) flash_rdata <= ~flash_rdata;
    else if (flash_req.aux) flash_rdata <= flash_req.row[0] ?
      tbl[flash_req.col] : prot[flash_req.col];
    else flash_rdata <= user[{flash_req.row, flash_req.col}];
    if (flash_req.ld) latch[flash_req.col] <= flash_req.wdata;
    op_q <= flash_req.op;
    run <= (flash_req.op == OP_NONE) ? 0 : run + 1;
    if (flash_req.op == OP_NONE && op_q != OP_NONE) pulse_len <= run;
    // a new pulse target (op, all, aux) acts once, also without a gap
    tgt_q <= {flash_req.op, flash_req.all, flash_req.aux};
    if (flash_req.op != OP_NONE &&
        {flash_req.op, flash_req.all, flash_req.aux} != tgt_q)
      apply(flash_req);
  end
endmodule // frse_mem

// File: test/flash_row_service_engine_test.sv
/*
  flash_row_service_engine_test: self-checking bench of frse_top.
  Assumes frse_mem as sram and flash, poked directly by the bench.
*/
`timescale 1ns/1ps
module flash_row_service_engine_test;
  import frse_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic clk_en = 1;
  frse_apb_req_type apb_req = '0;
  frse_apb_resp_type apb_resp;
  frse_call_type core_call = '0;
  frse_core_type core_ctl;
  frse_sram_type sram_req;
  frse_flash_type flash_req;
  logic [7:0] sram_rdata;
  logic [7:0] flash_rdata;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] acc_got, x_got, r, r2, ptr, dv, dl, p, nw;
  logic acc_seen, x_seen, err;
  logic [7:0] img [64];
  logic [7:0] oldp [64];
  logic [7:0] tsav [64];
  logic [7:0] cmds [2] = '{CMD_PROG, CMD_ERASE};
  logic [31:0] rd;
  frse_top dut_u (.clk(clk), .reset(reset), .clk_en(clk_en),
    .apb_req(apb_req), .apb_resp(apb_resp), .core_call(core_call),
    .core_ctl(core_ctl), .sram_rdata(sram_rdata), .sram_req(sram_req),
    .flash_rdata(flash_rdata), .flash_req(flash_req));
  frse_mem mem_u (.clk(clk), .sram_req(sram_req), .sram_rdata(sram_rdata),
    .flash_req(flash_req), .flash_rdata(flash_rdata));
  initial forever #12.5 clk = ~clk;
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (core_ctl.acc_we) begin
      acc_got <= core_ctl.acc;
      acc_seen <= 1'b1;
    end
    if (core_ctl.x_we) begin
      x_got <= core_ctl.x;
      x_seen <= 1'b1;
    end
    if (cycles == 95000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (apb_resp.pready === 1'b1) break;
    end
    if (apb_resp.pready !== 1'b1) n_mismatch++;
    rd = apb_resp.prdata;
    err = apb_resp.pslverr;
    apb_req <= '0;
  endtask
  task automatic call(input logic [7:0] cmd, input logic [7:0] blk,
                      input logic [7:0] k1);
    logic [7:0] sp;
    sp = $urandom;
    mem_u.sram[8'hf8] = k1;
    mem_u.sram[8'hf9] = sp;
    mem_u.sram[8'hfa] = blk;
    mem_u.sram[8'hfb] = ptr;
    mem_u.sram[8'hfc] = dv;
    mem_u.sram[8'hfe] = dl;
    acc_seen = 1'b0;
    x_seen = 1'b0;
    @(posedge clk);
    core_call <= '{1'b1, cmd, sp};
    @(posedge clk);
    core_call <= '0;
    @(posedge clk);
    if (k1 == FIRST_GUARD_KEY_VAL) check(core_ctl.stall, 1);
    for (int i = 0; i < 60000; i++) begin
      if (k1 == FIRST_GUARD_KEY_VAL ? core_ctl.stall === 1'b0 : core_ctl.halt === 1'b1)
        break;
      @(posedge clk);
    end
  endtask
  function automatic logic [15:0] csum(input int rows);
    logic [15:0] s;
    s = 0;
    for (int j = 0; j < rows * 64; j++) s += (j / 64 == r) ? img[j % 64] : 8'hff;
    return s;
  endfunction
  initial begin
    void'($urandom(32183));
    for (int i = 0; i < 16384; i++) mem_u.user[i] = 8'hff;
    for (int i = 0; i < 256; i++) mem_u.sram[i] = 8'h00;
    for (int i = 0; i < 64; i++) begin
      tsav[i] = $urandom;
      mem_u.tbl[i] = tsav[i];
      mem_u.prot[i] = 8'h00;
    end
    dv = 8'h01;
    dl = 8'h02;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    apb(0, CTRL_OFF, 0);
    check(rd, 1);
    apb(0, 12'h00c, 0);
    check(err, 1);
    $display("apb done");
    r = $urandom_range(127);
    ptr = $urandom_range(63);
    for (int i = 0; i < 64; i++) begin
      img[i] = $urandom;
      mem_u.sram[ptr + i] = img[i];
    end
    call(CMD_PROG, r, FIRST_GUARD_KEY_VAL);
    for (int i = 0; i < 64; i++) check(mem_u.user[{r, i[5:0]}], img[i]);
    check(mem_u.sram[8'hf8], RES_OK);
    $display("program done");
    for (int i = 0; i < 64; i++) begin
      p = $urandom & 8'h55;
      mem_u.prot[i] = p;
      nw = $urandom & 8'h55;
      if (i == r[7:2]) nw = nw | (8'h03 << {r[1:0], 1'b0});
      mem_u.sram[8'h80 + i] = nw;
      oldp[i] = p | nw;
    end
    call(CMD_MERGE, 0, FIRST_GUARD_KEY_VAL);
    for (int i = 0; i < 64; i++) check(mem_u.prot[i], oldp[i]);
    $display("merge done");
    foreach (cmds[c]) begin
      call(cmds[c], r, FIRST_GUARD_KEY_VAL);
      check(mem_u.sram[8'hf8], RES_PROT);
      check(mem_u.sram[8'hf9], 8'h00);
      check({acc_seen, acc_got}, 9'h100);
      check(mem_u.user[{r, 6'h05}], img[5]);
    end
    $display("refusal done");
    r2 = r ^ 8'h01;
    for (int i = 0; i < 64; i++) mem_u.user[{r2, i[5:0]}] = i[7:0];
    call(CMD_ERASE, r2, FIRST_GUARD_KEY_VAL);
    for (int i = 0; i < 64; i++) check(mem_u.user[{r2, i[5:0]}], 8'hff);
    check(mem_u.user[{r, 6'h00}], img[0]);
    check(mem_u.prot[r2[7:2]], oldp[r2[7:2]]);
    check(mem_u.pulse_len, (dv + 1) * (dl + 1));
    check(mem_u.sram[8'hf8], RES_OK);
    $display("erase done");
    for (int n = 0; n < 2; n++) begin
      call(CMD_CSUM, n == 0 ? r + 8'h01 : 8'h00, FIRST_GUARD_KEY_VAL);
      check(mem_u.sram[8'hf8], csum(n == 0 ? r + 1 : 256) & 16'h00ff);
      check(mem_u.sram[8'hf9], csum(n == 0 ? r + 1 : 256) >> 8);
    end
    $display("checksum done");
    for (int t = 0; t < 2; t++) begin
      call(CMD_TABLE, 8'hf8 | t[7:0], FIRST_GUARD_KEY_VAL);
      for (int i = 0; i < 8; i++) check(mem_u.sram[8'hf8 + i], tsav[t * 8 + i]);
      if (t == 0) check({acc_seen, x_seen, acc_got, x_got}, {2'b11, DIE_REV});
      else check({acc_seen, x_seen, acc_got, x_got}, {2'b11, INT_REV, XREG_TRIM});
    end
    $display("table done");
    mem_u.user[100] = 8'h00;
    call(CMD_BULK, 0, FIRST_GUARD_KEY_VAL);
    for (int i = 0; i < 16384; i += 97) check(mem_u.user[i], 8'hff);
    for (int i = 0; i < 64; i++) check(mem_u.prot[i], 8'h00);
    for (int i = 0; i < 64; i++) check(mem_u.tbl[i], tsav[i]);
    $display("bulk done");
    mem_u.user[0] = 8'h00;
    call(CMD_ERASE, 0, 8'h3b);
    check(core_ctl.halt, 1);
    check(mem_u.user[0], 8'h00);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(core_ctl.halt, 0);
    $display("halt done");
    final_report();
  end
endmodule // flash_row_service_engine_test
